// [hw/sfr_feature_regs.sv]
// Feature and status register bank behind the serial command link
`timescale 1ns/1ns
`default_nettype none
`include "sfr_consts.svh"
// Notes on behaviour
// - Get and set feature commands take one address byte choosing the register.
// - Status register is read only; write permit latch set by write enable command.
// - Written settings hold until power cycle or rewrite; soft reset keeps them.
// - Addresses A0 protection, B0 config, C0 status, D0 drive, F0 extended status.
// - Protection writes ignored while write gate set and write protect pin low.
// - Quad IO allowed only when quad bit set; powers up 0, soft reset keeps.
// - A0, B0, D0 read and write; C0, F0 read only, writes ignored.
// - OTP lock bit survives power loss; all other bits volatile.
// - Range bits power up 1, flip and complement 0; soft reset keeps them.
// - ECC enable powers up 1, soft reset keeps it, clearing disables ECC.
// - Freeze bit set blocks protection changes until power cycle; defaults 0.
// - ECC fields clear on soft reset and read start; update on read done.
// - ECC fields are not to be trusted while internal ECC is disabled.
// - After power-on reset ECC fields show the block 0 page 0 read outcome.
// - ECC result 00 clean, 01 corrected one to four, 10 uncorrected, 11 reserved.
// - Pending bit reads 1 while program, read, erase or reset runs.
// - Drive strength defaults 00 for 100, 75, 50, 25 percent codes.
module sfr_feature_regs (
  // Clock, reset, enable
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  // Serial link
  input  wire logic        i_sck,
  input  wire logic        i_cs_n,
  input  wire logic        i_si,
  input  wire logic        i_wp_n,
  output logic             o_so,
  output logic             o_so_oe,
  // Array engine status
  input  wire logic        i_array_busy,
  input  wire logic        i_read_start,
  input  wire logic        i_read_done,
  input  wire logic [1:0]  i_ecc_result,
  input  wire logic [1:0]  i_ecc_count,
  input  wire logic        i_prog_fail,
  input  wire logic        i_erase_fail,
  input  wire logic        i_wpl_clear,
  input  wire logic        i_otp_nv_lock,
  input  wire logic        i_block_protect_state,
  // Settings to the device
  output logic [7:0]       o_protect,
  output logic             o_quad_io_allow,
  output logic             o_ecc_enable,
  output logic             o_otp_enable,
  output logic             o_otp_lock,
  output logic [1:0]       o_drive_strength_sel,
  output logic             o_write_permit_latch,
  output logic             o_op_pending,
  output logic             o_soft_reset,
  output logic             o_power_reset
);
  localparam int RST_CYC_I = (`SFR_T_RST_NS + `SFR_CLK_NS - 1) / `SFR_CLK_NS;
  localparam logic [7:0] RST_CYC = RST_CYC_I[7:0];

  sfr_pkg::sfr_state_t st_q;
  sfr_pkg::sfr_rx_t    rx;
  sfr_pkg::sfr_ecc_t   ecc_in;
  sfr_pkg::sfr_ecc_t   ecc_q;
  logic [7:0]          cmd_q;
  logic [7:0]          addr_q;
  logic [7:0]          prot_q;
  logic                otp_en_q;
  logic                otp_lock_q;
  logic                otp_nv_q;
  logic                nv_load_q;
  logic                ecc_en_q;
  logic                freeze_q;
  logic                quad_q;
  logic [1:0]          drive_q;
  logic                wpl_q;
  logic                pfail_q;
  logic                efail_q;
  logic                arm_q;
  logic [7:0]          busy_q;
  logic                tx_load;
  logic [7:0]          tx_byte;
  logic                vol_rst;
  logic                cmd_now;
  logic                addr_now;
  logic                wr_now;
  logic                soft_now;
  logic                por_now;
  logic                prot_lock;

  // Byte at a feature address, reserved bits read as zero
  function automatic logic [7:0] feat_read(input logic [7:0] adr);
    logic [7:0] v;
    v = 8'h00;
    if (adr == `SFR_ADR_PROT) begin
      v = prot_q;
    end else if (adr == `SFR_ADR_CFG) begin
      v[`SFR_CF_OTP_LOCK] = otp_lock_q | otp_nv_q;
      v[`SFR_CF_OTP_EN]   = otp_en_q;
      v[`SFR_CF_ECC_EN]   = ecc_en_q;
      v[`SFR_CF_FREEZE]   = freeze_q;
      v[`SFR_CF_QUAD]     = quad_q;
    end else if (adr == `SFR_ADR_STAT) begin
      v[`SFR_ST_ECC_HI:`SFR_ST_ECC_LO] = ecc_q.result;
      v[`SFR_ST_PFAIL]    = pfail_q;
      v[`SFR_ST_EFAIL]    = efail_q;
      v[`SFR_ST_WPL]      = wpl_q;
      v[`SFR_ST_PEND]     = o_op_pending;
    end else if (adr == `SFR_ADR_DRIVE) begin
      v[`SFR_DR_HI:`SFR_DR_LO] = drive_q;
    end else if (adr == `SFR_ADR_XSTAT) begin
      v[`SFR_ST_ECC_HI:`SFR_ST_ECC_LO] = ecc_q.count;
      v[`SFR_XS_BPS]      = i_block_protect_state;
    end
    return v;
  endfunction : feat_read

  // Command decode events
  assign cmd_now   = i_ce & rx.done & (st_q == sfr_pkg::SFR_IDLE) & ~i_cs_n;
  assign addr_now  = i_ce & rx.done & (st_q == sfr_pkg::SFR_ADDR) & ~i_cs_n;
  assign wr_now    = i_ce & rx.done & (st_q == sfr_pkg::SFR_WDATA) & ~i_cs_n;
  assign soft_now  = cmd_now & (rx.byte_v == `SFR_CMD_SOFT_RST);
  assign por_now   = cmd_now & (rx.byte_v == `SFR_CMD_POR_GO) & arm_q;
  assign vol_rst   = i_rst | o_power_reset;
  assign prot_lock = (prot_q[`SFR_PR_GATE] & ~i_wp_n) | freeze_q;
  assign tx_load   = (addr_now & (cmd_q == `SFR_CMD_GET_FEAT))
                   | (i_ce & rx.done & (st_q == sfr_pkg::SFR_RDATA));
  assign tx_byte   = addr_now ? feat_read(rx.byte_v) : feat_read(addr_q);
  assign ecc_in    = '{result: i_ecc_result, count: i_ecc_count};

  sfr_spi_shift u_shift (
    .i_mclk    (i_mclk),
    .i_rst     (vol_rst),
    .i_ce      (i_ce),
    .i_sck     (i_sck),
    .i_cs_n    (i_cs_n),
    .i_si      (i_si),
    .o_so      (o_so),
    .i_tx_load (tx_load),
    .i_tx_byte (tx_byte),
    .o_rx      (rx)
  );

  sfr_ecc_stat u_ecc (
    .i_mclk  (i_mclk),
    .i_rst   (vol_rst),
    .i_ce    (i_ce),
    .i_clear (soft_now | i_read_start),
    .i_done  (i_read_done),
    .i_ecc   (ecc_in),
    .o_ecc   (ecc_q)
  );

  // Link sequencing
  always_ff @(posedge i_mclk) begin
    if (vol_rst) begin
      st_q   <= sfr_pkg::SFR_IDLE;
      cmd_q  <= 8'h00;
      addr_q <= 8'h00;
    end else if (i_ce) begin
      if (i_cs_n) begin
        st_q <= sfr_pkg::SFR_IDLE;
      end else if (rx.done) begin
        case (st_q)
          sfr_pkg::SFR_IDLE: begin
            cmd_q <= rx.byte_v;
            if (rx.byte_v == `SFR_CMD_GET_FEAT || rx.byte_v == `SFR_CMD_SET_FEAT) begin
              st_q <= sfr_pkg::SFR_ADDR;
            end else begin
              st_q <= sfr_pkg::SFR_SKIP;
            end
          end
          sfr_pkg::SFR_ADDR: begin
            addr_q <= rx.byte_v;
            if (cmd_q == `SFR_CMD_GET_FEAT) begin
              st_q <= sfr_pkg::SFR_RDATA;
            end else begin
              st_q <= sfr_pkg::SFR_WDATA;
            end
          end
          sfr_pkg::SFR_WDATA: st_q <= sfr_pkg::SFR_SKIP;
          sfr_pkg::SFR_RDATA: st_q <= sfr_pkg::SFR_RDATA;
          sfr_pkg::SFR_SKIP:  st_q <= sfr_pkg::SFR_SKIP;
          default:            st_q <= sfr_pkg::SFR_IDLE;
        endcase
      end
    end
  end

  // Output enable while the read data phase runs
  always_ff @(posedge i_mclk) begin
    if (vol_rst) begin
      o_so_oe <= 1'b0;
    end else if (i_ce) begin
      o_so_oe <= ~i_cs_n & (st_q == sfr_pkg::SFR_RDATA);
    end
  end

  // Protection register
  always_ff @(posedge i_mclk) begin
    if (vol_rst) begin
      prot_q <= `SFR_PR_RST;
    end else if (wr_now && addr_q == `SFR_ADR_PROT && !prot_lock) begin
      prot_q <= {rx.byte_v[`SFR_PR_GATE], 1'b0,
                 rx.byte_v[`SFR_PR_RANGE_HI:`SFR_PR_COMPL], 1'b0};
    end
  end

  // Configuration register; soft reset command does not touch it
  always_ff @(posedge i_mclk) begin
    if (vol_rst) begin
      otp_en_q  <= 1'b0;
      otp_lock_q <= 1'b0;
      ecc_en_q  <= 1'b1;
      freeze_q  <= 1'b0;
      quad_q    <= 1'b0;
    end else if (wr_now && addr_q == `SFR_ADR_CFG) begin
      otp_en_q  <= rx.byte_v[`SFR_CF_OTP_EN];
      otp_lock_q <= rx.byte_v[`SFR_CF_OTP_LOCK];
      ecc_en_q  <= rx.byte_v[`SFR_CF_ECC_EN];
      freeze_q  <= freeze_q | rx.byte_v[`SFR_CF_FREEZE];
      quad_q    <= rx.byte_v[`SFR_CF_QUAD];
    end
  end

  // Retained lock, caught after reset release
  always_ff @(posedge i_mclk) begin
    if (vol_rst) begin
      nv_load_q <= 1'b1;
      otp_nv_q  <= 1'b0;
    end else if (i_ce && nv_load_q) begin
      nv_load_q <= 1'b0;
      otp_nv_q  <= i_otp_nv_lock;
    end
  end

  // Drive strength register
  always_ff @(posedge i_mclk) begin
    if (vol_rst) begin
      drive_q <= 2'h0;
    end else if (wr_now && addr_q == `SFR_ADR_DRIVE) begin
      drive_q <= rx.byte_v[`SFR_DR_HI:`SFR_DR_LO];
    end
  end

  // Write permit latch: set wins over clear
  always_ff @(posedge i_mclk) begin
    if (vol_rst) begin
      wpl_q <= 1'b0;
    end else if (i_ce) begin
      if (cmd_now && rx.byte_v == `SFR_CMD_WR_ENABLE) begin
        wpl_q <= 1'b1;
      end else if (i_wpl_clear || soft_now
                   || (cmd_now && rx.byte_v == `SFR_CMD_WR_DISABLE)) begin
        wpl_q <= 1'b0;
      end
    end
  end

  // Fail flags from the array engine, cleared by reset command
  always_ff @(posedge i_mclk) begin
    if (vol_rst) begin
      pfail_q <= 1'b0;
      efail_q <= 1'b0;
    end else if (i_ce) begin
      pfail_q <= i_prog_fail | (pfail_q & ~soft_now);
      efail_q <= i_erase_fail | (efail_q & ~soft_now);
    end
  end

  // Reset commands and busy time
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      arm_q         <= 1'b0;
      busy_q        <= 8'h00;
      o_soft_reset  <= 1'b0;
      o_power_reset <= 1'b0;
    end else if (i_ce) begin
      o_soft_reset  <= soft_now;
      o_power_reset <= por_now;
      if (cmd_now) begin
        arm_q <= (rx.byte_v == `SFR_CMD_POR_ARM);
      end
      if (soft_now || por_now) begin
        busy_q <= RST_CYC;
      end else if (busy_q != 8'h00) begin
        busy_q <= busy_q - 8'h01;
      end
    end
  end

  // Registered setting outputs
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_protect            <= `SFR_PR_RST;
      o_quad_io_allow      <= 1'b0;
      o_ecc_enable         <= 1'b1;
      o_otp_enable         <= 1'b0;
      o_otp_lock           <= 1'b0;
      o_drive_strength_sel <= 2'h0;
      o_write_permit_latch <= 1'b0;
      o_op_pending         <= 1'b0;
    end else if (i_ce) begin
      o_protect            <= prot_q;
      o_quad_io_allow      <= quad_q;
      o_ecc_enable         <= ecc_en_q;
      o_otp_enable         <= otp_en_q;
      o_otp_lock           <= otp_lock_q | otp_nv_q;
      o_drive_strength_sel <= drive_q;
      o_write_permit_latch <= wpl_q;
      o_op_pending         <= i_array_busy | (busy_q != 8'h00) | soft_now | por_now;
    end
  end

  property p_wpl_set;
    @(posedge i_mclk) disable iff (i_rst)
      (cmd_now && rx.byte_v == `SFR_CMD_WR_ENABLE) |=> wpl_q ##1 o_write_permit_latch;
  endproperty
  a_wpl_set: assert property (p_wpl_set) else $error("write enable did not set latch");

  property p_wp_block;
    @(posedge i_mclk) disable iff (i_rst)
      (wr_now && addr_q == `SFR_ADR_PROT && prot_q[`SFR_PR_GATE] && !i_wp_n) |=> $stable(prot_q);
  endproperty
  a_wp_block: assert property (p_wp_block) else $error("protection written under pin lock");

  property p_freeze_keep;
    @(posedge i_mclk) disable iff (vol_rst)
      (freeze_q && !vol_rst) |=> freeze_q && $stable(prot_q);
  endproperty
  a_freeze_keep: assert property (p_freeze_keep) else $error("frozen protection changed");

  property p_soft_keep;
    @(posedge i_mclk) disable iff (i_rst)
      soft_now |=> $stable(quad_q) && $stable(ecc_en_q) && $stable(prot_q) && $stable(drive_q);
  endproperty
  a_soft_keep: assert property (p_soft_keep) else $error("soft reset changed a setting");

  property p_ecc_clear;
    @(posedge i_mclk) disable iff (vol_rst)
      (soft_now && !i_read_done) |=> ecc_q == '0;
  endproperty
  a_ecc_clear: assert property (p_ecc_clear) else $error("ecc status not cleared");

  property p_ecc_update;
    @(posedge i_mclk) disable iff (vol_rst)
      (i_ce && i_read_done) |=> ecc_q.result == $past(i_ecc_result);
  endproperty
  a_ecc_update: assert property (p_ecc_update) else $error("ecc result not captured");

  property p_pending;
    @(posedge i_mclk) disable iff (vol_rst)
      (i_ce && soft_now) |=> o_op_pending [*8];
  endproperty
  a_pending: assert property (p_pending) else $error("pending dropped during reset");

  property p_ro_status;
    @(posedge i_mclk) disable iff (vol_rst)
      (wr_now && addr_q == `SFR_ADR_STAT) |=> $stable(wpl_q) || $past(i_wpl_clear);
  endproperty
  a_ro_status: assert property (p_ro_status) else $error("status write took effect");

  property p_read_oe;
    @(posedge i_mclk) disable iff (vol_rst)
      (i_ce && !i_cs_n && st_q == sfr_pkg::SFR_RDATA) |=> o_so_oe;
  endproperty
  a_read_oe: assert property (p_read_oe) else $error("read data not driven");

  c_get: cover property (@(posedge i_mclk) addr_now && cmd_q == `SFR_CMD_GET_FEAT);
  c_set: cover property (@(posedge i_mclk) wr_now && addr_q == `SFR_ADR_CFG);
  c_por: cover property (@(posedge i_mclk) por_now);
endmodule : sfr_feature_regs
`default_nettype wire

// [hw/sfr_consts.svh]
// Constants of the serial NAND feature register bank
`ifndef SFR_CONSTS_SVH
`define SFR_CONSTS_SVH
// Serial commands
`define SFR_CMD_GET_FEAT   8'h0F
`define SFR_CMD_SET_FEAT   8'h1F
`define SFR_CMD_WR_ENABLE  8'h06
`define SFR_CMD_WR_DISABLE 8'h04
`define SFR_CMD_SOFT_RST   8'hFF
`define SFR_CMD_POR_ARM    8'h66
`define SFR_CMD_POR_GO     8'h99
// Feature addresses
`define SFR_ADR_PROT       8'hA0
`define SFR_ADR_CFG        8'hB0
`define SFR_ADR_STAT       8'hC0
`define SFR_ADR_DRIVE      8'hD0
`define SFR_ADR_XSTAT      8'hF0
// Protection register fields
`define SFR_PR_GATE        7
`define SFR_PR_RANGE_HI    5
`define SFR_PR_RANGE_LO    3
`define SFR_PR_FLIP        2
`define SFR_PR_COMPL       1
`define SFR_PR_RST         8'h38
// Configuration register fields
`define SFR_CF_OTP_LOCK    7
`define SFR_CF_OTP_EN      6
`define SFR_CF_ECC_EN      4
`define SFR_CF_FREEZE      3
`define SFR_CF_QUAD        0
// Status and extended status fields
`define SFR_ST_ECC_HI      5
`define SFR_ST_ECC_LO      4
`define SFR_ST_PFAIL       3
`define SFR_ST_EFAIL       2
`define SFR_ST_WPL         1
`define SFR_ST_PEND        0
`define SFR_XS_BPS         3
// Drive strength field
`define SFR_DR_HI          6
`define SFR_DR_LO          5
// Busy time after a reset command, and last bit index of a byte
`define SFR_T_RST_NS       500
`define SFR_CLK_NS         50
`define SFR_BIT_LAST       3'h7
`endif

// [hw/sfr_pkg.sv]
// Types of the serial NAND feature register bank
package sfr_pkg;
  typedef enum logic [4:0] {
    SFR_IDLE  = 5'h01,
    SFR_ADDR  = 5'h02,
    SFR_WDATA = 5'h04,
    SFR_RDATA = 5'h08,
    SFR_SKIP  = 5'h10
  } sfr_state_t;
  typedef struct packed {
    logic [1:0] result;
    logic [1:0] count;
  } sfr_ecc_t;
  typedef struct packed {
    logic [7:0] byte_v;
    logic       done;
  } sfr_rx_t;
endpackage : sfr_pkg

// [hw/sfr_spi_shift.sv]
// Serial byte shifter: bits in on clock rise, bits out on clock fall
`timescale 1ns/1ns
`default_nettype none
`include "sfr_consts.svh"
module sfr_spi_shift (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  // Serial pins
  input  wire logic        i_sck,
  input  wire logic        i_cs_n,
  input  wire logic        i_si,
  output logic             o_so,
  // Byte side
  input  wire logic        i_tx_load,
  input  wire logic [7:0]  i_tx_byte,
  output sfr_pkg::sfr_rx_t o_rx
);
  logic       sck_q;
  logic [2:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic       rise;
  logic       fall;
  assign rise = i_sck & ~sck_q;
  assign fall = ~i_sck & sck_q;
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      sck_q <= 1'b0;
    end else if (i_ce) begin
      sck_q <= i_sck;
    end
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cnt_q <= 3'h0;
      sh_q  <= 8'h00;
      o_rx  <= '0;
    end else if (i_ce) begin
      o_rx.done <= 1'b0;
      if (i_cs_n) begin
        cnt_q <= 3'h0;
      end else if (rise) begin
        sh_q  <= {sh_q[6:0], i_si};
        cnt_q <= cnt_q + 3'h1;
        if (cnt_q == `SFR_BIT_LAST) begin
          o_rx.byte_v <= {sh_q[6:0], i_si};
          o_rx.done   <= 1'b1;
        end
      end
    end
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      tx_q <= 8'h00;
      o_so <= 1'b0;
    end else if (i_ce) begin
      if (i_tx_load) begin
        tx_q <= i_tx_byte;
      end else if (fall && !i_cs_n) begin
        o_so <= tx_q[7];
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end
endmodule : sfr_spi_shift
`default_nettype wire

// [hw/sfr_ecc_stat.sv]
// ECC result and count holder, cleared by reset or read start
`timescale 1ns/1ns
`default_nettype none
module sfr_ecc_stat (
  // Clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_rst,
  input  wire logic         i_ce,
  // Events
  input  wire logic         i_clear,
  input  wire logic         i_done,
  input  wire sfr_pkg::sfr_ecc_t i_ecc,
  // Held status
  output sfr_pkg::sfr_ecc_t o_ecc
);
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_ecc <= '0;
    end else if (i_ce) begin
      if (i_done) begin
        o_ecc <= i_ecc;
      end else if (i_clear) begin
        o_ecc <= '0;
      end
    end
  end
endmodule : sfr_ecc_stat
`default_nettype wire

// [dv/sfr_host_model.sv]
// Host-side serial controller model that frames feature commands
`timescale 1ns/1ns
`default_nettype none
module sfr_host_model (
  // Clock
  input  wire logic i_mclk,
  // Serial pins
  output logic      o_sck,
  output logic      o_cs_n,
  output logic      o_si,
  input  wire logic i_so
);
  int half = 4;
  initial begin
    o_sck  = 1'b0;
    o_cs_n = 1'b1;
    o_si   = 1'b0;
  end
  // Data line toggles while deselected so a stale bit never looks like data
  always @(posedge i_mclk) begin
    if (o_cs_n) begin
      o_si <= ~o_si;
    end
  end
  // One byte, MSB first: data set while clock low, reply read at its rise
  task xfer(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      @(posedge i_mclk);
      o_sck <= 1'b0;
      o_si  <= b[i];
      repeat (half - 1) @(posedge i_mclk);
      @(posedge i_mclk);
      o_sck <= 1'b1;
      r[i] = i_so;
      repeat (half - 1) @(posedge i_mclk);
    end
  endtask : xfer
  // Command, then address, then data byte; clock parked low outside frames
  task frame(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d,
             input int n, output logic [7:0] r);
    logic [7:0] junk;
    r = 8'h00;
    @(posedge i_mclk);
    o_cs_n <= 1'b0;
    xfer(c, junk);
    if (n > 1) xfer(a, junk);
    if (n > 2) xfer(d, r);
    @(posedge i_mclk);
    o_sck <= 1'b0;
    repeat (half) @(posedge i_mclk);
    o_cs_n <= 1'b1;
    repeat (half) @(posedge i_mclk);
  endtask : frame
endmodule : sfr_host_model
`default_nettype wire

// [dv/sfr_feature_regs_tb_top.sv]
// Self-checking bench for the serial NAND feature register bank
`timescale 1ns/1ns
`default_nettype none
module sfr_feature_regs_tb_top;
  logic       i_mclk, i_rst, i_ce, i_sck, i_cs_n, i_si, i_wp_n;
  logic       i_array_busy, i_read_start, i_read_done, i_prog_fail, i_erase_fail;
  logic       i_wpl_clear, i_otp_nv_lock, i_block_protect_state;
  logic [1:0] i_ecc_result, i_ecc_count, o_drive_strength_sel;
  logic       o_so, o_so_oe, o_quad_io_allow, o_ecc_enable, o_otp_enable, o_otp_lock;
  logic       o_write_permit_latch, o_op_pending, o_soft_reset, o_power_reset;
  logic [7:0] o_protect;
  int         error_cnt = 0, n_tests = 0, cyc = 0, n_soft = 0, n_por = 0, n_pend = 0;
  int         s0, p0;

  sfr_feature_regs dut (.i_mclk, .i_rst, .i_ce, .i_sck, .i_cs_n, .i_si, .i_wp_n, .o_so,
    .o_so_oe, .i_array_busy, .i_read_start, .i_read_done, .i_ecc_result, .i_ecc_count,
    .i_prog_fail, .i_erase_fail, .i_wpl_clear, .i_otp_nv_lock, .i_block_protect_state,
    .o_protect, .o_quad_io_allow, .o_ecc_enable, .o_otp_enable, .o_otp_lock,
    .o_drive_strength_sel, .o_write_permit_latch, .o_op_pending, .o_soft_reset,
    .o_power_reset);
  sfr_host_model host (.i_mclk, .o_sck(i_sck), .o_cs_n(i_cs_n), .o_si(i_si), .i_so(o_so));

  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end
  // Pulse counters and run limit
  always @(posedge i_mclk) begin
    n_soft += int'(o_soft_reset === 1'b1);
    n_por  += int'(o_power_reset === 1'b1);
    n_pend += int'(o_op_pending === 1'b1);
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      end_sim();
    end
  end

  task end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] r;
    host.frame(8'h0F, a, 8'h00, 3, r);
    chk8(r, exp);
    chk8({7'h00, o_so_oe}, 8'h00);
  endtask : rd
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    host.frame(8'h1F, a, d, 3, r);
    repeat (4) @(posedge i_mclk);
  endtask : wr
  task cmd(input logic [7:0] c);
    logic [7:0] r;
    host.frame(c, 8'h00, 8'h00, 1, r);
    repeat (6) @(posedge i_mclk);
  endtask : cmd
  task ev(input int k);
    @(posedge i_mclk);
    case (k)
      0: i_read_start <= 1'b1;
      1: i_read_done <= 1'b1;
      2: i_prog_fail <= 1'b1;
      3: i_erase_fail <= 1'b1;
      default: i_wpl_clear <= 1'b1;
    endcase
    @(posedge i_mclk);
    {i_read_start, i_read_done, i_prog_fail, i_erase_fail, i_wpl_clear} <= 5'h00;
    repeat (4) @(posedge i_mclk);
  endtask : ev
  task do_reset;
    @(posedge i_mclk);
    i_rst <= 1'b1;
    repeat (5) @(posedge i_mclk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_mclk);
  endtask : do_reset
  task tend(input string s);
    $display("test %0s done", s);
  endtask : tend

  initial begin
    i_rst = 1'b1;
    i_ce = 1'b1;
    i_wp_n = 1'b1;
    {i_array_busy, i_read_start, i_read_done, i_prog_fail, i_erase_fail} = 5'h00;
    {i_wpl_clear, i_otp_nv_lock} = 2'h0;
    i_block_protect_state = 1'b1;
    i_ecc_result = 2'h1;
    i_ecc_count = 2'h2;
    do_reset();
    // Defaults, with the boot read result
    ev(1);
    rd(8'hA0, 8'h38);
    rd(8'hB0, 8'h10);
    rd(8'hC0, 8'h10);
    rd(8'hD0, 8'h00);
    rd(8'hF0, 8'h28);
    chk8({o_protect}, 8'h38);
    chk8({6'h00, o_ecc_enable, o_quad_io_allow}, 8'h02);
    chk8({7'h00, o_otp_lock}, 8'h00);
    tend("defaults");
    // Read-write and read-only places
    wr(8'hA0, 8'h2C);
    rd(8'hA0, 8'h2C);
    chk8(o_protect, 8'h2C);
    wr(8'hB0, 8'h01);
    rd(8'hB0, 8'h01);
    chk8({6'h00, o_ecc_enable, o_quad_io_allow}, 8'h01);
    for (int k = 0; k < 4; k++) begin
      wr(8'hD0, {1'b0, 2'(k), 5'h00});
      rd(8'hD0, {1'b0, 2'(k), 5'h00});
      chk8({6'h00, o_drive_strength_sel}, 8'(k));
    end
    wr(8'hC0, 8'h3F);
    wr(8'hF0, 8'h30);
    rd(8'hC0, 8'h10);
    rd(8'hF0, 8'h28);
    tend("access");
    // Write permit latch
    cmd(8'h06);
    rd(8'hC0, 8'h12);
    chk8({7'h00, o_write_permit_latch}, 8'h01);
    cmd(8'h04);
    rd(8'hC0, 8'h10);
    cmd(8'h06);
    ev(4);
    rd(8'hC0, 8'h10);
    tend("latch");
    // Status events and soft reset
    @(posedge i_mclk);
    i_array_busy <= 1'b1;
    repeat (4) @(posedge i_mclk);
    chk8({7'h00, o_op_pending}, 8'h01);
    rd(8'hC0, 8'h11);
    i_array_busy <= 1'b0;
    ev(2);
    ev(3);
    rd(8'hC0, 8'h1C);
    ev(0);
    rd(8'hC0, 8'h0C);
    i_ecc_result <= 2'h2;
    i_ecc_count <= 2'h3;
    ev(1);
    rd(8'hC0, 8'h2C);
    rd(8'hF0, 8'h38);
    s0 = n_soft;
    p0 = n_pend;
    cmd(8'hFF);
    repeat (20) @(posedge i_mclk);
    chk8(8'(n_soft - s0), 8'h01);
    chk8({7'h00, n_pend > p0}, 8'h01);
    rd(8'hC0, 8'h00);
    rd(8'hF0, 8'h08);
    rd(8'hA0, 8'h2C);
    rd(8'hB0, 8'h01);
    rd(8'hD0, 8'h60);
    tend("status");
    // Write gate with protect pin
    wr(8'hA0, 8'hB8);
    rd(8'hA0, 8'hB8);
    i_wp_n <= 1'b0;
    wr(8'hA0, 8'h00);
    rd(8'hA0, 8'hB8);
    i_wp_n <= 1'b1;
    wr(8'hA0, 8'h00);
    rd(8'hA0, 8'h00);
    tend("gate");
    // Freeze, then power reset commands
    wr(8'hB0, 8'h18);
    rd(8'hB0, 8'h18);
    wr(8'hA0, 8'h38);
    wr(8'hA0, 8'h80);
    rd(8'hA0, 8'h00);
    cmd(8'hFF);
    repeat (20) @(posedge i_mclk);
    rd(8'hB0, 8'h18);
    s0 = n_por;
    cmd(8'h99);
    chk8(8'(n_por - s0), 8'h00);
    cmd(8'h66);
    cmd(8'h99);
    chk8(8'(n_por - s0), 8'h01);
    repeat (30) @(posedge i_mclk);
    rd(8'hA0, 8'h38);
    rd(8'hB0, 8'h10);
    rd(8'hD0, 8'h00);
    tend("freeze");
    // Retained lock bit, slow host
    host.half = 6;
    i_otp_nv_lock <= 1'b1;
    do_reset();
    rd(8'hB0, 8'h90);
    chk8({7'h00, o_otp_lock}, 8'h01);
    rd(8'hA0, 8'h38);
    tend("retain");
    end_sim();
  end
endmodule : sfr_feature_regs_tb_top
`default_nettype wire
